/* File: hw/ocs_octet_control_status.sv */
// ocs_octet_control_status.sv: control/status word of one octet of an eight-line
// serial multiplexer, reached over an axi4-lite slave.
// assumes: one clock aclk, synchronous active-low aresetn; the octet
// logic drives its event and self-test inputs synchronously to aclk.
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`include "ocs_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module ocs_octet_control_status #(
  parameter int ADDR_W      = 8,
  parameter int MRST_CYCLES = `OCS_MRST_MAX_US * `OCS_CLK_MHZ,
  parameter int RX_TMO      = `OCS_RX_TMO_CYC,
  parameter int RX_BURST    = `OCS_RX_BURST
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // octet side
  input  wire logic              bus_init,
  input  wire logic              tx_last_moved,
  input  wire logic [2:0]        tx_last_line,
  input  wire logic              rx_silo_has_data,
  input  wire logic              rx_char_entered,
  input  wire logic              selftest_done,
  input  wire logic              selftest_pass,
  output logic                   octet_reset,
  output logic [1:0]             ind_reg_num,
  output logic [2:0]             ind_reg_line,
  output logic                   tx_vector_req,
  output logic                   rx_vector_req,
  output logic                   irq
);

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  if (ADDR_W < 6 || ADDR_W > 32) begin : g_bad_addr
    $error("ocs_octet_control_status: ADDR_W must be 6 to 32");
  end
  if (MRST_CYCLES < 2 || RX_TMO < 1 || RX_BURST < 1 || RX_BURST > 255) begin : g_bad_cnt
    $error("ocs_octet_control_status: counts out of range");
  end

  // ----------------------------------------------------------------------
  // address decode, shared by read and write paths
  // ----------------------------------------------------------------------
  function automatic ocs_pkg::ocs_sel_t sel_of(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-3:0] idx;
    idx = a[ADDR_W-1:2];
    if (a[1:0] != 2'h0)
      sel_of = ocs_pkg::OCS_SEL_NONE;
    else if (idx == (ADDR_W-2)'(`OCS_CSR_IDX))
      sel_of = ocs_pkg::OCS_SEL_CSR;
    else if (idx == (ADDR_W-2)'(`OCS_IRQ_STAT_IDX))
      sel_of = ocs_pkg::OCS_SEL_STAT;
    else if (idx == (ADDR_W-2)'(`OCS_IRQ_CLR_IDX))
      sel_of = ocs_pkg::OCS_SEL_CLR;
    else if (idx == (ADDR_W-2)'(`OCS_IRQ_EN_IDX))
      sel_of = ocs_pkg::OCS_SEL_EN;
    else
      sel_of = ocs_pkg::OCS_SEL_NONE;
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  ocs_pkg::ocs_csr_t      csr;
  ocs_pkg::ocs_mr_state_t mr_state;
  logic [ADDR_W-1:0]      aw_addr;
  logic                   aw_held;
  logic [31:0]            w_data;
  logic [3:0]             w_strb;
  logic                   w_held;
  logic                   rx_avail;
  logic [$clog2(RX_TMO+1)-1:0]   rx_tmo_cnt;
  logic                   rx_tmo_hit;
  logic [7:0]             rx_char_cnt;
  logic                   rx_burst_hit;
  logic [$clog2(MRST_CYCLES+1)-1:0] mr_cnt;
  logic [`OCS_IRQ_NUM-1:0] irq_stat;
  logic [`OCS_IRQ_NUM-1:0] irq_en;
  logic [`OCS_IRQ_NUM-1:0] irq_event;

  // ----------------------------------------------------------------------
  // bus handshakes and strobes
  // ----------------------------------------------------------------------
  logic              wr_fire;
  ocs_pkg::ocs_sel_t wr_sel;
  logic              rd_fire;
  ocs_pkg::ocs_sel_t rd_sel;
  logic              csr_wr;
  logic              csr_rd;
  logic              mr_start;
  logic              mr_ok;
  logic              mr_bad;
  logic              rx_req_now;
  logic [15:0]       csr_word;

  assign wr_fire  = aw_held && w_held && !s_axi_bvalid;
  assign wr_sel   = sel_of(aw_addr);
  assign rd_fire  = s_axi_arvalid && s_axi_arready;
  assign rd_sel   = sel_of(s_axi_araddr);
  // a control/status write landing mid-reset does nothing at all
  assign csr_wr   = wr_fire && wr_sel == ocs_pkg::OCS_SEL_CSR
                    && mr_state != ocs_pkg::OCS_MR_BUSY;
  assign csr_rd   = rd_fire && rd_sel == ocs_pkg::OCS_SEL_CSR;
  assign mr_start = csr_wr && w_strb[0] && w_data[`OCS_MRST_BIT];
  // a missing self-test answer by the deadline counts as a failure
  assign mr_bad   = mr_state == ocs_pkg::OCS_MR_BUSY
                    && ((selftest_done && !selftest_pass)
                        || (!selftest_done && mr_cnt == '0));
  assign mr_ok    = mr_state == ocs_pkg::OCS_MR_BUSY && selftest_done && selftest_pass;
  assign rx_req_now = csr.rx_ie && (rx_tmo_hit || rx_burst_hit);

  // bits 13, 12 and 11 have no storage here and read as zero
  assign csr_word = {csr.tx_ready, csr.tx_ie, 2'h0, 1'b0, csr.tx_line,
                     rx_avail, csr.rx_ie, mr_state != ocs_pkg::OCS_MR_IDLE,
                     csr.ind_num, csr.ind_line};

  // ----------------------------------------------------------------------
  // write address and data channels
  // ----------------------------------------------------------------------
  // ready is a one-cycle pulse so every output stays a flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_held       <= 1'b0;
      aw_addr       <= '0;
    end else begin
      s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_held && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_held       <= 1'b0;
      w_data       <= '0;
      w_strb       <= '0;
    end else begin
      s_axi_wready <= s_axi_wvalid && !s_axi_wready && !w_held && !s_axi_bvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response; unmapped offsets answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `OCS_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_sel == ocs_pkg::OCS_SEL_NONE) ? `OCS_RESP_SLVERR : `OCS_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `OCS_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `OCS_RESP_OKAY;
        case (rd_sel)
          ocs_pkg::OCS_SEL_CSR:  s_axi_rdata <= {16'h0000, csr_word};
          ocs_pkg::OCS_SEL_STAT: s_axi_rdata <= {28'h0000000, irq_stat};
          ocs_pkg::OCS_SEL_EN:   s_axi_rdata <= {28'h0000000, irq_en};
          ocs_pkg::OCS_SEL_CLR:  s_axi_rdata <= '0;
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= `OCS_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // master reset sequencer
  // ----------------------------------------------------------------------
  // only this octet's logic sees octet_reset; other octets keep running
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mr_state    <= ocs_pkg::OCS_MR_IDLE;
      mr_cnt      <= '0;
      octet_reset <= 1'b0;
    end else if (bus_init) begin
      mr_state    <= ocs_pkg::OCS_MR_IDLE;
      mr_cnt      <= '0;
      octet_reset <= 1'b0;
    end else begin
      case (mr_state)
        ocs_pkg::OCS_MR_IDLE, ocs_pkg::OCS_MR_FAIL: begin
          // a failed octet may be retried by a fresh write
          if (mr_start) begin
            mr_state    <= ocs_pkg::OCS_MR_BUSY;
            mr_cnt      <= ($bits(mr_cnt))'(MRST_CYCLES - 1);
            octet_reset <= 1'b1;
          end
        end
        ocs_pkg::OCS_MR_BUSY: begin
          mr_cnt <= mr_cnt - 1'b1;
          if (mr_ok) begin
            mr_state    <= ocs_pkg::OCS_MR_IDLE;
            octet_reset <= 1'b0;
          end else if (mr_bad) begin
            mr_state    <= ocs_pkg::OCS_MR_FAIL;
            octet_reset <= 1'b0;
          end
        end
        default: begin
          mr_state    <= ocs_pkg::OCS_MR_IDLE;
          octet_reset <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || bus_init || mr_start) begin
      csr.tx_ie    <= 1'b0;
      csr.rx_ie    <= 1'b0;
      csr.ind_num  <= 2'h0;
      csr.ind_line <= 3'h0;
    end else if (csr_wr) begin
      if (w_strb[1])
        csr.tx_ie <= w_data[`OCS_TX_IE_BIT];
      if (w_strb[0]) begin
        csr.rx_ie    <= w_data[`OCS_RX_IE_BIT];
        csr.ind_num  <= w_data[`OCS_IND_NUM_HI:`OCS_IND_NUM_LO];
        csr.ind_line <= w_data[`OCS_IND_LINE_HI:`OCS_IND_LINE_LO];
      end
    end
  end

  // transmit ready and its line; a new event beats a same-cycle read
  always_ff @(posedge aclk) begin
    if (!aresetn || bus_init || mr_start) begin
      csr.tx_ready <= 1'b0;
      csr.tx_line  <= 3'h0;
    end else if (tx_last_moved) begin
      csr.tx_ready <= 1'b1;
      csr.tx_line  <= tx_last_line;
    end else if (csr_rd) begin
      csr.tx_ready <= 1'b0;
      csr.tx_line  <= 3'h0;
    end
  end

  // ----------------------------------------------------------------------
  // receive side: availability, timeout and burst count
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || bus_init || mr_start || octet_reset)
      rx_avail <= 1'b0;
    else
      rx_avail <= rx_silo_has_data;
  end

  // timeout counts only while data waits; emptying rearms it
  always_ff @(posedge aclk) begin
    if (!aresetn || !rx_avail) begin
      rx_tmo_cnt <= '0;
      rx_tmo_hit <= 1'b0;
    end else if (rx_tmo_cnt == ($bits(rx_tmo_cnt))'(RX_TMO)) begin
      rx_tmo_hit <= 1'b1;
    end else begin
      rx_tmo_cnt <= rx_tmo_cnt + 1'b1;
    end
  end

  // burst hit holds until the silo drains or octet_reset clears it
  always_ff @(posedge aclk) begin
    if (!aresetn || octet_reset || !rx_silo_has_data) begin
      rx_char_cnt  <= 8'h00;
      rx_burst_hit <= 1'b0;
    end else if (rx_char_entered) begin
      if (rx_char_cnt == 8'(RX_BURST - 1)) begin
        rx_char_cnt  <= 8'h00;
        rx_burst_hit <= 1'b1;
      end else begin
        rx_char_cnt <= rx_char_cnt + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // vector requests
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_vector_req <= 1'b0;
      rx_vector_req <= 1'b0;
    end else begin
      tx_vector_req <= csr.tx_ie && csr.tx_ready;
      rx_vector_req <= rx_req_now;
    end
  end

  // ----------------------------------------------------------------------
  // interrupt status, enable and line
  // ----------------------------------------------------------------------
  assign irq_event[`OCS_IRQ_TX]        = tx_last_moved && csr.tx_ie;
  assign irq_event[`OCS_IRQ_RX]        = rx_req_now && !rx_vector_req;
  assign irq_event[`OCS_IRQ_MRST_OK]   = mr_ok;
  assign irq_event[`OCS_IRQ_MRST_FAIL] = mr_bad;

  // sticky bits; an event beats a clear in the same cycle
  for (genvar i = 0; i < `OCS_IRQ_NUM; i++) begin : g_irq
    always_ff @(posedge aclk) begin
      if (!aresetn)
        irq_stat[i] <= 1'b0;
      else if (irq_event[i])
        irq_stat[i] <= 1'b1;
      else if (wr_fire && wr_sel == ocs_pkg::OCS_SEL_CLR && w_strb[0] && w_data[i])
        irq_stat[i] <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      irq_en <= '0;
    else if (wr_fire && wr_sel == ocs_pkg::OCS_SEL_EN && w_strb[0])
      irq_en <= w_data[`OCS_IRQ_NUM-1:0];
  end

  // one cycle behind status/enable, kept registered
  always_ff @(posedge aclk) begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(irq_stat & irq_en);
  end

  // ----------------------------------------------------------------------
  // indirect selectors out to the indirect register bank
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ind_reg_num  <= 2'h0;
      ind_reg_line <= 3'h0;
    end else begin
      ind_reg_num  <= csr.ind_num;
      ind_reg_line <= csr.ind_line;
    end
  end

endmodule // ocs_octet_control_status

`default_nettype wire

/* File: hw/ocs_defs.svh */
// ocs_defs.svh: offsets, field positions, reset values and timing counts
// of the octet control/status block.
// assumes: included by bare name; holds definitions only.
`ifndef OCS_DEFS_SVH
`define OCS_DEFS_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define OCS_CSR_IDX       8'h00
`define OCS_IRQ_STAT_IDX  8'h08
`define OCS_IRQ_CLR_IDX   8'h09
`define OCS_IRQ_EN_IDX    8'h0a
`define OCS_IND_LINE_IDX  8'h06

// ----------------------------------------------------------------------
// control/status field positions
// ----------------------------------------------------------------------
`define OCS_TX_READY_BIT  15
`define OCS_TX_IE_BIT     14
`define OCS_TX_LINE_HI    10
`define OCS_TX_LINE_LO    8
`define OCS_RX_AVAIL_BIT  7
`define OCS_RX_IE_BIT     6
`define OCS_MRST_BIT      5
`define OCS_IND_NUM_HI    4
`define OCS_IND_NUM_LO    3
`define OCS_IND_LINE_HI   2
`define OCS_IND_LINE_LO   0
`define OCS_CSR_RESET     16'h0000

// ----------------------------------------------------------------------
// interrupt status bits
// ----------------------------------------------------------------------
`define OCS_IRQ_NUM       4
`define OCS_IRQ_TX        0
`define OCS_IRQ_RX        1
`define OCS_IRQ_MRST_OK   2
`define OCS_IRQ_MRST_FAIL 3

// ----------------------------------------------------------------------
// timing and bus answers
// ----------------------------------------------------------------------
`define OCS_MRST_MAX_US   500
`define OCS_CLK_MHZ       100
`define OCS_RX_TMO_CYC    1000
`define OCS_RX_BURST      64
`define OCS_RESP_OKAY     2'h0
`define OCS_RESP_SLVERR   2'h2

`endif

/* File: hw/ocs_pkg.sv */
// ocs_pkg.sv: types shared by the octet control/status block.
// assumes: numeric constants live in ocs_defs.svh.
package ocs_pkg;

  // master reset sequencer states
  typedef enum logic [1:0] {
    OCS_MR_IDLE,
    OCS_MR_BUSY,
    OCS_MR_FAIL
  } ocs_mr_state_t;

  // software-visible fields of the control/status word
  typedef struct packed {
    logic       tx_ready;
    logic       tx_ie;
    logic [2:0] tx_line;
    logic       rx_ie;
    logic [1:0] ind_num;
    logic [2:0] ind_line;
  } ocs_csr_t;

  // register selected by a bus address
  typedef enum logic [2:0] {
    OCS_SEL_CSR,
    OCS_SEL_STAT,
    OCS_SEL_CLR,
    OCS_SEL_EN,
    OCS_SEL_NONE
  } ocs_sel_t;

endpackage

/* File: tb/ocs_asserts.sv */
// ocs_asserts.sv: port-level checker for the octet control/status block.
// assumes: bound into every ocs_octet_control_status; one clock, sync active-low reset.
`timescale 1ns/100ps
`default_nettype none

module ocs_asserts #(
  parameter int MRST_CYCLES = 50000
) (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic       bus_init,
  input wire logic       selftest_done,
  input wire logic       octet_reset,
  input wire logic [1:0] ind_reg_num,
  input wire logic [2:0] ind_reg_line
);
  // ------------------------------------------------------------------
  // helper: length of the running master reset
  // ------------------------------------------------------------------
  localparam int MR_LIM = MRST_CYCLES + 2;
  int mr_len;

  // a counter, since a repetition this long would choke the tools
  always_ff @(posedge aclk) begin
    if (!aresetn || !octet_reset) mr_len <= 0;
    else mr_len <= mr_len + 1;
  end

  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_st_answer;
    octet_reset && selftest_done && !bus_init;
  endsequence

  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held two cycles");
  a_w_pulse: assert property (s_axi_wready |=> !s_axi_wready)
    else $error("wready held two cycles");
  // answer rises two edges after the later take: held, then fired
  a_b_after_take: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_awready || s_axi_wready, 2))
    else $error("write answer without a take");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  a_r_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  a_mrst_ends: assert property (s_st_answer |=> !octet_reset)
    else $error("octet reset outlived self-test answer");
  a_mrst_bound: assert property (mr_len <= MR_LIM)
    else $error("octet reset too long");
  a_init_clears: assert property (bus_init [*2] |=>
    !octet_reset && ind_reg_num == 2'h0 && ind_reg_line == 3'h0)
    else $error("init left state behind");
endmodule // ocs_asserts

bind ocs_octet_control_status ocs_asserts #(.MRST_CYCLES(MRST_CYCLES)) chk_u (.*);

`default_nettype wire

/* File: tb/ocs_octet_model.sv */
// ocs_octet_model.sv: octet logic answering the self-test of a master reset.
// assumes: mode 0 pass, 1 fail, 2 never answers; delay below MRST_CYCLES.
`timescale 1ns/100ps
`default_nettype none

module ocs_octet_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       octet_reset,
  input  wire logic [1:0] mode,
  input  wire logic [7:0] delay,
  output logic            selftest_done,
  output logic            selftest_pass
);
  logic [7:0] age;

  // cycles since the octet reset began; saturates
  always_ff @(posedge aclk) begin
    if (!aresetn || !octet_reset) age <= 8'h00;
    else if (age != 8'hff) age <= age + 8'h01;
  end

  // pass line toggles off the answer so a stale level is never trusted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      selftest_done <= 1'b0;
      selftest_pass <= 1'b0;
    end else begin
      selftest_done <= octet_reset && age == delay && mode != 2'h2;
      if (octet_reset && age == delay) selftest_pass <= mode == 2'h0;
      else selftest_pass <= !selftest_pass;
    end
  end
endmodule // ocs_octet_model

`default_nettype wire

/* File: tb/testbench.sv */
// testbench.sv: self-checking bench for the octet control/status block.
// assumes: ocs_octet_model answers self-tests; checker bound to the design.
`timescale 1ns/100ps
`default_nettype none
`include "ocs_defs.svh"

module testbench;
  localparam int MRC = 40;
  localparam int TMO = 200;
  localparam logic [7:0] A_CSR = `OCS_CSR_IDX << 2;
  localparam logic [7:0] A_ST = `OCS_IRQ_STAT_IDX << 2;
  localparam logic [7:0] A_CLR = `OCS_IRQ_CLR_IDX << 2;
  localparam logic [7:0] A_EN = `OCS_IRQ_EN_IDX << 2;
  logic aclk = 1'b0, aresetn = 1'b0, bus_init = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_v;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, ind_reg_num, rd_r, mode = 2'h0;
  logic tx_last_moved = 1'b0, rx_silo_has_data = 1'b0, rx_char_entered = 1'b0;
  logic [2:0] tx_last_line = 3'h0, ind_reg_line;
  logic selftest_done, selftest_pass, octet_reset, tx_vector_req, rx_vector_req, irq;
  int failures = 0;
  int check_count = 0;

  always #5 aclk = ~aclk;

  ocs_octet_control_status #(.MRST_CYCLES(MRC), .RX_TMO(TMO)) dut_u (.*);
  ocs_octet_model model_u (.aclk(aclk), .aresetn(aresetn), .octet_reset(octet_reset),
    .mode(mode), .delay(8'h19), .selftest_done(selftest_done), .selftest_pass(selftest_pass));

  // ------------------------------------------------------------------
  // reporting and bus cycles
  // ------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic hang(input string what);
    failures++;
    $display("[ERR] %0t no answer: %s", $time, what);
    tally_and_finish();
  endtask

  // each channel released only at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    if (!s_axi_bvalid) hang("write");
    rd_r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    if (!s_axi_rvalid) hang("read");
    rd_v = s_axi_rdata;
    rd_r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    rd(a);
    chk(rd_v, exp, what);
    chk({30'h0, rd_r}, {30'h0, `OCS_RESP_OKAY}, what);
  endtask

  task automatic pulse_tx(input logic [2:0] ln);
    @(posedge aclk);
    tx_last_moved <= 1'b1;
    tx_last_line <= ln;
    @(posedge aclk);
    tx_last_moved <= 1'b0;
    tx_last_line <= ~ln; // line is junk outside the strobe
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset_vals();
    rdc(A_CSR, 32'h0, "csr after reset");
    rdc(A_ST, 32'h0, "status after reset");
    wr(8'h14, 32'hffff_ffff, 4'hf);
    chk({30'h0, rd_r}, {30'h0, `OCS_RESP_SLVERR}, "unmapped write");
    rd(8'h14);
    chk({30'h0, rd_r}, {30'h0, `OCS_RESP_SLVERR}, "unmapped read");
  endtask

  task automatic t_fields();
    wr(A_CSR, 32'h0000_ffdf, 4'h3);
    rdc(A_CSR, 32'h0000_405f, "only writable fields kept");
    chk({27'h0, ind_reg_num, ind_reg_line}, 32'h1f, "indirect selectors");
  endtask

  task automatic t_tx_irq();
    wr(A_EN, 32'h0, 4'h1);
    pulse_tx(3'h5);
    repeat (2) @(posedge aclk);
    chk({31'h0, tx_vector_req}, 32'h1, "tx vector");
    chk({31'h0, irq}, 32'h0, "irq masked");
    rdc(A_ST, 32'h1, "tx event status");
    wr(A_EN, 32'h1, 4'h1);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h1, "irq enabled");
    wr(A_CLR, 32'h1, 4'h1);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    rdc(A_ST, 32'h0, "status cleared");
    rdc(A_CSR, 32'h0000_c55f, "tx ready and line");
    rdc(A_CSR, 32'h0000_405f, "cleared by read");
    repeat (2) @(posedge aclk);
    chk({31'h0, tx_vector_req}, 32'h0, "tx vector off");
  endtask

  task automatic t_rx();
    int n;
    @(posedge aclk);
    rx_silo_has_data <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!rx_vector_req && n < TMO + 20);
    chk({31'h0, n >= TMO && n <= TMO + 6}, 32'h1, "rx timeout");
    rdc(A_CSR, 32'h0000_40df, "rx available");
    rdc(A_ST, 32'h2, "rx status");
    rx_silo_has_data <= 1'b0;
    // avail, then hit, then the registered request each take an edge
    repeat (4) @(posedge aclk);
    chk({31'h0, rx_vector_req}, 32'h0, "rx vector off");
    rdc(A_CSR, 32'h0000_405f, "rx drained");
    rx_silo_has_data <= 1'b1;
    for (n = 0; n < 64; n++) begin
      if (n == 63) chk({31'h0, rx_vector_req}, 32'h0, "before 64th");
      @(posedge aclk);
      rx_char_entered <= 1'b1;
      @(posedge aclk);
      rx_char_entered <= 1'b0;
    end
    repeat (2) @(posedge aclk);
    chk({31'h0, rx_vector_req}, 32'h1, "64 characters");
    rx_silo_has_data <= 1'b0;
  endtask

  task automatic t_mrst(input logic [1:0] m, input logic [31:0] after);
    int n;
    mode <= m;
    wr(A_CSR, 32'h0000_003f, 4'h1);
    rdc(A_CSR, 32'h0000_0020, "reset running");
    wr(A_CSR, 32'h0000_0047, 4'h1);
    rdc(A_CSR, 32'h0000_0020, "write ignored");
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (octet_reset && n < MRC + 10);
    if (octet_reset) hang("master reset");
    rdc(A_CSR, after, "reset outcome");
    rd(A_ST);
    chk({31'h0, rd_v[(m == 2'h0) ? `OCS_IRQ_MRST_OK : `OCS_IRQ_MRST_FAIL]},
        32'h1, "reset event status");
    // cleared so the next outcome is seen fresh
    wr(A_CLR, 32'h0000_000c, 4'h1);
  endtask

  task automatic t_init();
    wr(A_CSR, 32'h0000_405f, 4'h3);
    rx_silo_has_data <= 1'b1;
    pulse_tx(3'h2);
    bus_init <= 1'b1;
    rx_silo_has_data <= 1'b0;
    repeat (3) @(posedge aclk);
    bus_init <= 1'b0;
    rdc(A_CSR, 32'h0, "init clears");
    chk({27'h0, ind_reg_num, ind_reg_line}, 32'h0, "selectors after init");
  endtask

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_vals();
    t_fields();
    t_tx_irq();
    t_rx();
    t_mrst(2'h1, 32'h0000_0020);
    wr(A_CSR, 32'h0000_0003, 4'h1);
    rdc(A_CSR, 32'h0000_0023, "writable after failure");
    t_mrst(2'h2, 32'h0000_0020);
    t_mrst(2'h0, 32'h0);
    t_init();
    tally_and_finish();
  end
endmodule // testbench

`default_nettype wire
